//--- logic/pcc_cfg_regs.vh
// Constants for the capability configuration window: offsets, fields and resets.
// Assumes byte addressing of 32-bit configuration words over a Wishbone bus.
`ifndef PCC_CFG_REGS_VH
`define PCC_CFG_REGS_VH

// Byte offsets of the configuration registers.
`define PCC_OFS_LINK_TUNE      8'hA4
`define PCC_OFS_SUBSYS_CAP     8'hA8
`define PCC_OFS_CARD_IDS       8'hAC
`define PCC_OFS_EXPRESS_CAP    8'hB0
`define PCC_OFS_CHAIN_CTRL     8'hE0

// Link power tuning fields.
`define PCC_L0S_GATE_BIT       16
`define PCC_SCRAMBLE_LSB       17
`define PCC_SCRAMBLE_MSB       18
`define PCC_L1_TIMER_LSB       19
`define PCC_L1_TIMER_MSB       20
`define PCC_L0S_GATE_RST       1'h1
`define PCC_SCRAMBLE_RST       2'h0
`define PCC_L1_TIMER_RST       2'h1

// Capability identifiers and chain pointers.
`define PCC_SUBSYS_CAP_ID      8'h0D
`define PCC_EXPRESS_CAP_ID     8'h10
`define PCC_PTR_EXPRESS        8'hB0
`define PCC_PTR_SLOT_ID        8'hA0
`define PCC_PTR_LEGACY         8'hF0
`define PCC_EXPRESS_NEXT       8'hF0

// Express capability descriptor fields.
`define PCC_CAP_VERSION        4'h1
`define PCC_PORT_TYPE_RST      4'h7
`define PCC_SLOT_IMPL          1'h0
`define PCC_IRQ_MSG_NUM        5'h00

// Chain control fields.
`define PCC_SLOT_ID_EN_BIT     0
`define PCC_LEGACY_BIT         1
`define PCC_SLOT_ID_EN_RST     1'h0
`define PCC_LEGACY_RST         1'h0

`endif

//--- logic/pcc_rw_field.v
// Read-write register field with a constant reset value.
// Assumes the write strobe is already qualified by address and byte lane.
module pcc_rw_field #(
  parameter         W   = 1,
  parameter [W-1:0] RST = {W{1'h0}}
) (
  input  wire         i_clock,
  input  wire         i_nrst,
  input  wire         i_we,
  input  wire [W-1:0] i_data,
  output wire [W-1:0] o_q
);

  reg [W-1:0] field_q;

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      field_q <= RST;
    end else if (i_we) begin
      field_q <= i_data;
    end
  end

  assign o_q = field_q;

endmodule // pcc_rw_field

//--- logic/pcc_wb_port.v
// Classic Wishbone slave handshake: one registered acknowledge per request.
// Assumes the master holds the request stable until it samples the acknowledge.
module pcc_wb_port (
  input  wire i_clock,
  input  wire i_nrst,
  input  wire i_cyc,
  input  wire i_stb,
  input  wire i_we,
  output wire o_ack,
  output wire o_wr_en,
  output wire o_rd_load
);

  reg  ack_q;
  wire req;

  assign req = i_cyc & i_stb;

  // Acknowledge one cycle after the request; drop it in the following cycle.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_q <= 1'h0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  assign o_ack     = ack_q;
  assign o_wr_en   = req & i_we & ack_q;
  assign o_rd_load = req & ~ack_q;

endmodule // pcc_wb_port

//--- logic/pcc_cfg_space.v
// Capability configuration window: link power tuning, card_identifier capability,
// express capability header and the pointer chain that links them.
// Assumes a classic Wishbone master on i_clock and a link layer that reads
// the tuning outputs and reports receiver electrical idle synchronously.
//
// Implementation choice: register access over Wishbone.
`include "pcc_cfg_regs.vh"

module pcc_cfg_space #(
  parameter [15:0] CARD_VENDOR_ID = 16'h1A2B,
  parameter [15:0] CARD_ID        = 16'h3C4D,
  parameter [3:0]  PORT_TYPE      = `PCC_PORT_TYPE_RST
) (
  input  wire        i_clock,
  input  wire        i_nrst,
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [7:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output wire [31:0] o_wb_dat,
  output wire        o_wb_ack,
  input  wire        i_rx_elec_idle,
  output wire        o_l0s_entry_allow,
  output wire [1:0]  o_scramble_ctrl,
  output wire [1:0]  o_l1_timer_ctrl,
  output wire [7:0]  o_subsys_next_link,
  output wire        o_legacy_mode
);

  // Bus handshake.
  wire        wr_en;
  wire        rd_load;
  reg  [31:0] rdata_q;
  wire [31:0] rdata_d;

  // Decoded word selects.
  wire        sel_tune;
  wire        sel_ctrl;
  wire [7:0]  word_adr;
  wire        tune_wr;
  wire        ctrl_wr;

  // Writable field strobes.
  wire        we_l0s_gate;
  wire        we_scramble;
  wire        we_l1_timer;
  wire        we_slot_id_en;
  wire        we_legacy;

  // Writable field values.
  wire        l0s_gate;
  wire [1:0]  scramble;
  wire [1:0]  l1_timer;
  wire        slot_id_en;
  wire        legacy;

  // Composed read words.
  wire [31:0] tune_word;
  wire [31:0] subsys_word;
  wire [31:0] ids_word;
  wire [31:0] express_word;
  wire [31:0] ctrl_word;
  wire [7:0]  subsys_next;

  // Express capability descriptor fields.
  wire [1:0]  express_rsvd;
  wire [4:0]  irq_msg_num;
  wire        slot_impl;
  wire [3:0]  port_type;
  wire [3:0]  cap_version;

  // Registered link-facing outputs.
  reg         l0s_allow_q;
  wire        l0s_allow_d;
  reg  [1:0]  scramble_q;
  reg  [1:0]  l1_timer_q;
  reg  [7:0]  next_link_q;
  reg         legacy_q;

  // Word-aligned address match.
  function hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      hit = (adr[7:2] == ofs[7:2]);
    end
  endfunction

  pcc_wb_port u_wb_port (
    .i_clock   (i_clock),
    .i_nrst    (i_nrst),
    .i_cyc     (i_wb_cyc),
    .i_stb     (i_wb_stb),
    .i_we      (i_wb_we),
    .o_ack     (o_wb_ack),
    .o_wr_en   (wr_en),
    .o_rd_load (rd_load)
  );

  assign word_adr = {i_wb_adr[7:2], 2'h0};
  assign sel_tune = hit(i_wb_adr, `PCC_OFS_LINK_TUNE);
  assign sel_ctrl = hit(i_wb_adr, `PCC_OFS_CHAIN_CTRL);

  // Only writable bits get strobes; read-only and reserved bits have none.
  assign tune_wr       = wr_en & sel_tune & i_wb_sel[2];
  assign ctrl_wr       = wr_en & sel_ctrl & i_wb_sel[0];
  assign we_l0s_gate   = tune_wr;
  assign we_scramble   = tune_wr;
  assign we_l1_timer   = tune_wr;
  assign we_slot_id_en = ctrl_wr;
  assign we_legacy     = ctrl_wr;

  pcc_rw_field #(
    .W   (1),
    .RST (`PCC_L0S_GATE_RST)
  ) u_l0s_gate (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_we    (we_l0s_gate),
    .i_data  (i_wb_dat[`PCC_L0S_GATE_BIT]),
    .o_q     (l0s_gate)
  );

  pcc_rw_field #(
    .W   (2),
    .RST (`PCC_SCRAMBLE_RST)
  ) u_scramble (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_we    (we_scramble),
    .i_data  (i_wb_dat[`PCC_SCRAMBLE_MSB:`PCC_SCRAMBLE_LSB]),
    .o_q     (scramble)
  );

  pcc_rw_field #(
    .W   (2),
    .RST (`PCC_L1_TIMER_RST)
  ) u_l1_timer (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_we    (we_l1_timer),
    .i_data  (i_wb_dat[`PCC_L1_TIMER_MSB:`PCC_L1_TIMER_LSB]),
    .o_q     (l1_timer)
  );

  pcc_rw_field #(
    .W   (1),
    .RST (`PCC_SLOT_ID_EN_RST)
  ) u_slot_id_en (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_we    (we_slot_id_en),
    .i_data  (i_wb_dat[`PCC_SLOT_ID_EN_BIT]),
    .o_q     (slot_id_en)
  );

  pcc_rw_field #(
    .W   (1),
    .RST (`PCC_LEGACY_RST)
  ) u_legacy (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_we    (we_legacy),
    .i_data  (i_wb_dat[`PCC_LEGACY_BIT]),
    .o_q     (legacy)
  );

  // Legacy mode bypasses the express capability; slot ID capability
  // otherwise diverts the chain to the slot identification structure.
  assign subsys_next = legacy     ? `PCC_PTR_LEGACY :
                       slot_id_en ? `PCC_PTR_SLOT_ID :
                                    `PCC_PTR_EXPRESS;

  // Bits 15:0 of the tuning word belong to another block and read zero here.
  assign tune_word = {11'h0,
                      l1_timer,
                      scramble,
                      l0s_gate,
                      16'h0000};

  assign subsys_word = {16'h0000,
                        subsys_next,
                        `PCC_SUBSYS_CAP_ID};

  assign ids_word = {CARD_ID,
                     CARD_VENDOR_ID};

  assign express_rsvd = 2'h0;
  assign irq_msg_num  = `PCC_IRQ_MSG_NUM;
  assign slot_impl    = `PCC_SLOT_IMPL;
  assign port_type    = PORT_TYPE;
  assign cap_version  = `PCC_CAP_VERSION;

  assign express_word = {express_rsvd,
                         irq_msg_num,
                         slot_impl,
                         port_type,
                         cap_version,
                         `PCC_EXPRESS_NEXT,
                         `PCC_EXPRESS_CAP_ID};

  assign ctrl_word = {30'h0,
                      legacy,
                      slot_id_en};

  // Read multiplexer; unmapped words answer with zero.
  function [31:0] read_word;
    input [7:0]  adr;
    input [31:0] tune;
    input [31:0] subsys;
    input [31:0] ids;
    input [31:0] express;
    input [31:0] ctrl;
    begin
      case (adr)
        `PCC_OFS_LINK_TUNE:   read_word = tune;
        `PCC_OFS_SUBSYS_CAP:  read_word = subsys;
        `PCC_OFS_CARD_IDS:    read_word = ids;
        `PCC_OFS_EXPRESS_CAP: read_word = express;
        `PCC_OFS_CHAIN_CTRL:  read_word = ctrl;
        default:              read_word = 32'h00000000;
      endcase
    end
  endfunction

  assign rdata_d = read_word(word_adr,
                             tune_word,
                             subsys_word,
                             ids_word,
                             express_word,
                             ctrl_word);

  // Read data is captured in the cycle before the acknowledge and held.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= 32'h00000000;
    end else if (rd_load) begin
      rdata_q <= rdata_d;
    end
  end

  // L0s entry permission follows the gate bit and the receiver idle state.
  assign l0s_allow_d = l0s_gate ? i_rx_elec_idle : 1'h1;

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      l0s_allow_q <= 1'h0;
    end else begin
      l0s_allow_q <= l0s_allow_d;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      scramble_q <= `PCC_SCRAMBLE_RST;
    end else begin
      scramble_q <= scramble;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      l1_timer_q <= `PCC_L1_TIMER_RST;
    end else begin
      l1_timer_q <= l1_timer;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      next_link_q <= `PCC_PTR_EXPRESS;
    end else begin
      next_link_q <= subsys_next;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      legacy_q <= `PCC_LEGACY_RST;
    end else begin
      legacy_q <= legacy;
    end
  end

  assign o_wb_dat           = rdata_q;
  assign o_l0s_entry_allow  = l0s_allow_q;
  assign o_scramble_ctrl    = scramble_q;
  assign o_l1_timer_ctrl    = l1_timer_q;
  assign o_subsys_next_link = next_link_q;
  assign o_legacy_mode      = legacy_q;

endmodule // pcc_cfg_space

//--- testbench/pcc_cfg_checker.sv
// Port assertions for the capability configuration window.
// Assumes it is bound to pcc_cfg_space with the parameters handed on.
`include "pcc_cfg_regs.vh"
module pcc_cfg_checker #(
  parameter [15:0] CARD_VENDOR_ID = 16'h1A2B,
  parameter [15:0] CARD_ID        = 16'h3C4D,
  parameter [3:0]  PORT_TYPE      = `PCC_PORT_TYPE_RST
) (
  input wire logic        i_clock,
  input wire logic        i_nrst,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        i_rx_elec_idle,
  input wire logic        o_l0s_entry_allow,
  input wire logic [1:0]  o_scramble_ctrl,
  input wire logic [1:0]  o_l1_timer_ctrl,
  input wire logic [7:0]  o_subsys_next_link,
  input wire logic        o_legacy_mode
);
  wire [7:0] adr = {i_wb_adr[7:2], 2'h0};
  wire       rd  = o_wb_ack && !i_wb_we;
  wire       tw  = o_wb_ack && i_wb_cyc && i_wb_stb && i_wb_we &&
                   adr == `PCC_OFS_LINK_TUNE && i_wb_sel[2];
  wire [3:0] tune_wdat = i_wb_dat[20:17];
  logic      gate_q;
  logic      allow_q;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      gate_q  <= 1'h1;
      allow_q <= 1'h0;
    end else begin
      allow_q <= gate_q ? i_rx_elec_idle : 1'h1;
      if (tw) gate_q <= i_wb_dat[16];
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sequence s_take;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_pulse;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  property p_tune;
    tw |-> ##2 ({o_l1_timer_ctrl, o_scramble_ctrl} == $past(tune_wdat, 2));
  endproperty
  AST_ACK_PULSE: assert property (s_take |=> s_pulse)
    else $error("request not answered by one ack pulse");
  AST_L0S_GATE: assert property (o_l0s_entry_allow == allow_q)
    else $error("L0s permission wrong");
  AST_TUNE_FIELDS: assert property (p_tune)
    else $error("tuning outputs do not follow write");
  AST_SUBSYS_READ: assert property (rd && adr == `PCC_OFS_SUBSYS_CAP |->
    o_wb_dat == {16'h0000, o_subsys_next_link, `PCC_SUBSYS_CAP_ID})
    else $error("subsystem header read wrong");
  AST_NEXT_SET: assert property (o_subsys_next_link inside {8'hB0, 8'hA0, 8'hF0})
    else $error("next pointer outside legal set");
  AST_LEGACY_PTR: assert property (o_legacy_mode && $past(o_legacy_mode) |->
    o_subsys_next_link == 8'hF0) else $error("legacy pointer not F0");
  AST_IDS_READ: assert property (rd && adr == `PCC_OFS_CARD_IDS |->
    o_wb_dat == {CARD_ID, CARD_VENDOR_ID}) else $error("card ids read wrong");
  AST_EXPRESS_READ: assert property (rd && adr == `PCC_OFS_EXPRESS_CAP |->
    o_wb_dat == {2'h0, 5'h00, 1'h0, PORT_TYPE, 4'h1, 8'hF0, 8'h10})
    else $error("express header read wrong");
  AST_TUNE_RSVD: assert property (rd && adr == `PCC_OFS_LINK_TUNE |->
    o_wb_dat[31:21] == 11'h000 && o_wb_dat[15:0] == 16'h0000)
    else $error("reserved tuning bits not zero");
endmodule // pcc_cfg_checker
bind pcc_cfg_space pcc_cfg_checker #(
  .CARD_VENDOR_ID (CARD_VENDOR_ID),
  .CARD_ID        (CARD_ID),
  .PORT_TYPE      (PORT_TYPE)
) i_chk (
  .i_clock            (i_clock),
  .i_nrst             (i_nrst),
  .i_wb_cyc           (i_wb_cyc),
  .i_wb_stb           (i_wb_stb),
  .i_wb_we            (i_wb_we),
  .i_wb_adr           (i_wb_adr),
  .i_wb_sel           (i_wb_sel),
  .i_wb_dat           (i_wb_dat),
  .o_wb_dat           (o_wb_dat),
  .o_wb_ack           (o_wb_ack),
  .i_rx_elec_idle     (i_rx_elec_idle),
  .o_l0s_entry_allow  (o_l0s_entry_allow),
  .o_scramble_ctrl    (o_scramble_ctrl),
  .o_l1_timer_ctrl    (o_l1_timer_ctrl),
  .o_subsys_next_link (o_subsys_next_link),
  .o_legacy_mode      (o_legacy_mode)
);

//--- testbench/tb_top.sv
// Self-checking bench for the capability configuration window.
// Assumes one clock and a design answering each Wishbone request in turn.
`include "pcc_cfg_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0;
  logic        nrst = 1'h0;
  logic        cyc = 1'h0;
  logic        we = 1'h0;
  logic        idle = 1'h0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  wire  [31:0] rdat;
  wire         ack;
  wire         allow;
  wire         legacy;
  wire  [1:0]  scr;
  wire  [1:0]  tmr;
  wire  [7:0]  nxt;
  int          n_fail = 0;
  int          samples_checked = 0;
  always #12.5 clk = ~clk;
  pcc_cfg_space i_dut (.i_clock(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(cyc),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_rx_elec_idle(idle), .o_l0s_entry_allow(allow),
    .o_scramble_ctrl(scr), .o_l1_timer_ctrl(tmr), .o_subsys_next_link(nxt),
    .o_legacy_mode(legacy));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk);
    cyc  <= 1'h1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'h1 && k < 20);
    if (ack === 1'h1) begin
      r = rdat;
      cyc <= 1'h0;
    end else begin
      n_fail++;
      $display("[ERR] %0t no ack", $time);
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] r;
    bus(1'h1, a, s, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'h0, a, 4'hF, 32'h0, r);
    chk(r, e);
  endtask
  task automatic fixed_reads;
    rd(`PCC_OFS_SUBSYS_CAP, 32'h0000_B00D);
    rd(`PCC_OFS_CARD_IDS, 32'h3C4D_1A2B);
    rd(`PCC_OFS_EXPRESS_CAP, 32'h0071_F010);
  endtask
  task automatic t_reset;
    chk({legacy, nxt, tmr, scr}, {1'h0, 8'hB0, 2'h1, 2'h0});
    rd(`PCC_OFS_LINK_TUNE, 32'h0009_0000);
    fixed_reads();
    rd(8'hC0, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_tune;
    wr(`PCC_OFS_LINK_TUNE, 4'hB, 32'hFFFF_FFFF);
    rd(`PCC_OFS_LINK_TUNE, 32'h0009_0000);
    idle <= 1'h0;
    repeat (2) @(posedge clk);
    chk(allow, 1'h0);
    idle <= 1'h1;
    repeat (2) @(posedge clk);
    chk(allow, 1'h1);
    wr(`PCC_OFS_LINK_TUNE, 4'hF, 32'hFFFF_FFFF);
    rd(`PCC_OFS_LINK_TUNE, 32'h001F_0000);
    chk({tmr, scr}, 4'hF);
    wr(`PCC_OFS_LINK_TUNE, 4'hF, 32'h0);
    idle <= 1'h0;
    repeat (2) @(posedge clk);
    chk(allow, 1'h1);
    chk({tmr, scr}, 4'h0);
    $display("test tune done");
  endtask
  task automatic t_ro;
    wr(`PCC_OFS_SUBSYS_CAP, 4'hF, 32'hFFFF_FFFF);
    wr(`PCC_OFS_CARD_IDS, 4'hF, 32'h0);
    wr(`PCC_OFS_EXPRESS_CAP, 4'hF, 32'h0);
    fixed_reads();
    $display("test read-only done");
  endtask
  task automatic t_chain;
    wr(`PCC_OFS_CHAIN_CTRL, 4'hF, 32'h1);
    rd(`PCC_OFS_SUBSYS_CAP, 32'h0000_A00D);
    wr(`PCC_OFS_CHAIN_CTRL, 4'hF, 32'h3);
    wr(`PCC_OFS_SUBSYS_CAP, 4'hF, 32'h0000_B000);
    rd(`PCC_OFS_SUBSYS_CAP, 32'h0000_F00D);
    chk({legacy, nxt}, {1'h1, 8'hF0});
    wr(`PCC_OFS_CHAIN_CTRL, 4'hF, 32'h0);
    rd(`PCC_OFS_SUBSYS_CAP, 32'h0000_B00D);
    $display("test chain done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    t_reset();
    t_tune();
    t_ro();
    t_chain();
    wrap_up();
  end
endmodule // tb_top
